// file: fp_rbc_cfg.svh
// offsets, field positions and encodings of the rounding and bounce control
// ****************************************************************
// Notes on behaviour
// - four rounding modes applied when fitting results
// - nearest mode: ties go to even significand
// - toward zero mode truncates, never increments magnitude
// - stride bits 21:20, 00 is +1, 11 is +2
// - exceptional state bounces next instruction except exempt transfers
// - bounced instruction not processed, destination left untouched
// - enabled exception condition causes a user trap
// - unsupported operand values bounce to support code
// - exceptions from unsupported data trap when enabled
// - unused reserved bits read zero, software writes zero
// - unpredictable instructions never halt or hang
// - nonzero result below minimum normal is tiny
// - subnormals keep full precision of normal operands
// - potentially exceptional issue sets flag, captures instruction
// - flush mode turns subnormal inputs, results to +0
// ****************************************************************
`ifndef FP_RBC_CFG_SVH
`define FP_RBC_CFG_SVH

// word addresses on the register bus
`define OFS_STATUS_CTRL   3'h0
`define OFS_EXC_CTRL      3'h1
`define OFS_EXC_INSTR     3'h2
`define OFS_SYS_ID        3'h3
`define OFS_IRQ_STATUS    3'h4
`define OFS_IRQ_MASK      3'h5
`define OFS_LAST_RESULT   3'h6

// status/control fields
`define SC_FLAG_LSB       0
`define SC_FLAG_MSB       4
`define SC_IXC_BIT        4
`define SC_EN_LSB         8
`define SC_EN_MSB         12
`define SC_STRIDE_LSB     20
`define SC_STRIDE_MSB     21
`define SC_RMODE_LSB      22
`define SC_RMODE_MSB      23
`define SC_FTZ_BIT        24
`define SC_WMASK          32'h01F01F1F
`define SC_RESET          32'h00000000

// exception control and captured instruction
`define EXC_EX_BIT        31
`define INSTR_DEST_LSB    12
`define INSTR_DEST_MSB    15

// encodings
`define RM_NEAREST        2'h0
`define RM_PLUS_INF       2'h1
`define RM_MINUS_INF      2'h2
`define RM_ZERO           2'h3
`define STRIDE_TWO        2'h3
`define SYSSEL_EXC        2'h1
`define SYSSEL_INSTR      2'h2
`define SYSSEL_ID         2'h3

// interrupt status bits
`define IRQ_BOUNCE_BIT    0
`define IRQ_TRAP_BIT      1
`define IRQ_UNSUP_BIT     2
`define IRQ_W             3

`endif

// file: fp_rbc_chk.sv
// concurrent checks on the rounding and bounce control ports
`include "fp_rbc_cfg.svh"
`default_nettype none
module fp_rbc_chk
  import fp_rbc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        iss_valid,
  input wire iss_req_t    iss_req,
  input wire logic        iss_accept,
  input wire logic        iss_bounce,
  input wire logic        dp_issue,
  input wire logic        rnd_valid,
  input wire rnd_req_t    rnd_req,
  input wire logic        rnd_done,
  input wire logic        rnd_tiny,
  input wire logic        exc_valid,
  input wire logic        trap
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // nonzero value with a zero exponent sits below the normal range
  wire tiny_in = rnd_req.exp == 8'h00 && {rnd_req.sig, rnd_req.grs} != 27'h0;
  sequence s_access;
    (avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |-> s_access)
    else $error("bus access not answered after one wait state");
  a_bus_no_hang: assert property (not (avs_waitrequest [*3]))
    else $error("waitrequest held too long");
  a_reserved_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == `OFS_STATUS_CTRL
    |-> (avs_readdata & ~`SC_WMASK) == 32'h0)
    else $error("reserved status bits read nonzero");
  a_one_answer: assert property (iss_valid |=> iss_accept ^ iss_bounce)
    else $error("offer without exactly one answer");
  a_exempt_taken: assert property (
    iss_valid && iss_req.sysreg && iss_req.sysreg_sel != 2'h0 |=> iss_accept)
    else $error("exempt transfer was bounced");
  a_unsup_bounce: assert property (
    iss_valid && iss_req.unsup && !iss_req.sysreg |=> iss_bounce)
    else $error("unsupported operand not bounced");
  a_bounce_no_issue: assert property (iss_bounce |-> !dp_issue)
    else $error("bounced instruction reached datapath");
  a_tiny_class: assert property (
    rnd_valid |=> rnd_done && rnd_tiny == $past(tiny_in))
    else $error("tiny classification wrong");
  a_trap_cause: assert property (trap |-> $past(exc_valid || rnd_valid))
    else $error("trap without a raised condition");
endmodule
bind fp_round_bounce_control fp_rbc_chk i_chk (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .iss_valid(iss_valid), .iss_req(iss_req), .iss_accept(iss_accept),
  .iss_bounce(iss_bounce), .dp_issue(dp_issue), .rnd_valid(rnd_valid),
  .rnd_req(rnd_req), .rnd_done(rnd_done), .rnd_tiny(rnd_tiny),
  .exc_valid(exc_valid), .trap(trap)
);
`default_nettype wire

// file: fp_rbc_pkg.sv
// types shared by the rounding and bounce control block
`default_nettype none
package fp_rbc_pkg;

  // exceptional state of the unit
  typedef enum logic {
    ST_NORMAL,
    ST_EXCEPTIONAL
  } ex_state_t;

  // one instruction offered by the host core
  typedef struct packed {
    logic [31:0] instr;
    logic        pot_exc;
    logic        unsup;
    logic        sysreg;
    logic [1:0]  sysreg_sel;
    logic [2:0]  vec_iter;
  } iss_req_t;

  // exact value to be fitted to single precision
  typedef struct packed {
    logic        sign;
    logic [7:0]  exp;
    logic [23:0] sig;
    logic [2:0]  grs;
  } rnd_req_t;

endpackage
`default_nettype wire

// file: fp_round_bounce_control.sv
// rounding, vector stepping and exceptional-state bounce control
`include "fp_rbc_cfg.svh"
`default_nettype none
module fp_round_bounce_control
  import fp_rbc_pkg::*;
#(
  // arbitrary identification value
  parameter logic [31:0] SYS_ID_VALUE = 32'h00005A01
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register bus
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // instruction issue from the host core
  input  wire logic        iss_valid,
  input  wire iss_req_t    iss_req,
  output logic             iss_accept,
  output logic             iss_bounce,
  output logic             dp_issue,
  output logic      [31:0] dp_instr,
  // operand flush path
  input  wire logic [31:0] opnd_a_in,
  input  wire logic [31:0] opnd_b_in,
  output logic      [31:0] opnd_a_out,
  output logic      [31:0] opnd_b_out,
  // rounding path
  input  wire logic        rnd_valid,
  input  wire rnd_req_t    rnd_req,
  output logic             rnd_done,
  output logic      [31:0] rnd_result,
  output logic             rnd_tiny,
  output logic             rnd_inexact,
  // exception reports from the datapath
  input  wire logic        exc_valid,
  input  wire logic [4:0]  exc_flags,
  input  wire logic        exc_unsup,
  // event outputs
  output logic             trap,
  output logic             irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // single precision value in the subnormal range
  function automatic logic is_subnormal(input logic [31:0] v);
    is_subnormal = (v[30:23] == 8'h00) && (v[22:0] != 23'h000000);
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************

  logic [31:0]        sc_r;
  logic [31:0]        sc_nxt;
  ex_state_t          state_r;
  ex_state_t          state_nxt;
  logic [31:0]        inst_r;
  logic [31:0]        inst_nxt;
  logic [`IRQ_W-1:0]  irq_st_r;
  logic [`IRQ_W-1:0]  irq_st_nxt;
  logic [`IRQ_W-1:0]  irq_mask_r;
  logic [31:0]        last_res_r;
  logic               ack_r;
  logic [31:0]        rdata_r;
  logic               accept_r;
  logic               bounce_r;
  logic               dp_issue_r;
  logic [31:0]        dp_instr_r;
  logic [31:0]        opnd_a_r;
  logic [31:0]        opnd_b_r;
  logic               rnd_done_r;
  logic [31:0]        rnd_res_r;
  logic               rnd_tiny_r;
  logic               rnd_inx_r;
  logic               trap_r;

  // ****************************************************************
  // register bus slave
  // ****************************************************************

  // every access waits exactly one cycle, then completes
  wire bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;

  // write strobes, active on the completing edge only
  wire wr_go    = avs_write & ack_r;
  wire wr_sc    = wr_go & (avs_address == `OFS_STATUS_CTRL);
  wire wr_exc   = wr_go & (avs_address == `OFS_EXC_CTRL);
  wire wr_inst  = wr_go & (avs_address == `OFS_EXC_INSTR);
  wire wr_irqst = wr_go & (avs_address == `OFS_IRQ_STATUS);
  wire wr_mask  = wr_go & (avs_address == `OFS_IRQ_MASK);

  // ****************************************************************
  // status/control fields
  // ****************************************************************

  wire [1:0] rmode  = sc_r[`SC_RMODE_MSB:`SC_RMODE_LSB];
  wire [1:0] stride = sc_r[`SC_STRIDE_MSB:`SC_STRIDE_LSB];
  wire       ftz    = sc_r[`SC_FTZ_BIT];
  wire [4:0] exc_en = sc_r[`SC_EN_MSB:`SC_EN_LSB];

  // ****************************************************************
  // issue decode
  // ****************************************************************

  // transfers that reach the exception registers are never bounced
  wire sel_exempt = (iss_req.sysreg_sel == `SYSSEL_EXC) ||
                    (iss_req.sysreg_sel == `SYSSEL_INSTR) ||
                    (iss_req.sysreg_sel == `SYSSEL_ID);
  wire exempt     = iss_req.sysreg & sel_exempt;
  wire in_exc     = (state_r == ST_EXCEPTIONAL);

  wire trig_bounce  = iss_valid & in_exc & ~exempt;
  wire unsup_bounce = iss_valid & iss_req.unsup & ~iss_req.sysreg &
                      ~trig_bounce;
  wire bounce_now   = trig_bounce | unsup_bounce;

  // every offer is answered next cycle, whatever its encoding
  // never hang
  wire accept_now = iss_valid & ~bounce_now;
  wire enter_exc  = accept_now & iss_req.pot_exc & ~iss_req.sysreg;

  // ****************************************************************
  // vector iteration pointer
  // ****************************************************************

  logic [3:0] iter_dest;

  // faulting iteration's destination goes into the capture
  vec_reg_stepper u_step (
    .base_reg (iss_req.instr[`INSTR_DEST_MSB:`INSTR_DEST_LSB]),
    .stride   (stride),
    .iter     (iss_req.vec_iter),
    .iter_reg (iter_dest)
  );

  // ****************************************************************
  // exceptional state machine
  // ****************************************************************

  // leaving the state is software's job, by clearing the flag
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL: begin
        if (enter_exc || (wr_exc && avs_writedata[`EXC_EX_BIT]))
          state_nxt = ST_EXCEPTIONAL;
      end
      ST_EXCEPTIONAL: begin
        if (wr_exc && !avs_writedata[`EXC_EX_BIT] && !enter_exc)
          state_nxt = ST_NORMAL;
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  // capture beats a software write in the same cycle
  always_comb begin
    inst_nxt = inst_r;
    if (wr_inst)
      inst_nxt = avs_writedata;
    if (enter_exc) begin
      inst_nxt = iss_req.instr;
      inst_nxt[`INSTR_DEST_MSB:`INSTR_DEST_LSB] = iter_dest;
    end
  end

  // ****************************************************************
  // rounding path
  // ****************************************************************

  logic [24:0] sig_rnd;
  logic        inx;

  fp_round_unit u_round (
    .sign    (rnd_req.sign),
    .sig     (rnd_req.sig),
    .grs     (rnd_req.grs),
    .rmode   (rmode),
    .sig_out (sig_rnd),
    .inexact (inx)
  );

  wire tiny = (rnd_req.exp == 8'h00) && ((rnd_req.sig != 24'h000000) ||
              (rnd_req.grs != 3'h0));

  // renormalise after a carry out of the significand
  wire [7:0] exp_inc = rnd_req.exp + 8'h01;
  logic [31:0] packed_res;
  always_comb begin
    if (sig_rnd[24])
      packed_res = {rnd_req.sign, exp_inc, sig_rnd[23:1]};
    else if ((rnd_req.exp == 8'h00) && sig_rnd[23])
      packed_res = {rnd_req.sign, 8'h01, sig_rnd[22:0]};
    else
      packed_res = {rnd_req.sign, rnd_req.exp, sig_rnd[22:0]};
  end

  // flushed results carry positive sign, no rounding applied
  // flush result
  wire         flush_res = ftz & tiny;
  wire [31:0]  final_res = flush_res ? 32'h00000000 : packed_res;
  wire         final_inx = ~flush_res & inx;

  // ****************************************************************
  // exception flags and traps
  // ****************************************************************

  // datapath reports arrive whether or not support code helped
  wire [4:0] rnd_flag = (rnd_valid && final_inx) ? 5'h10 : 5'h00;
  wire [4:0] dp_flag  = exc_valid ? exc_flags : 5'h00;
  wire [4:0] new_flag = rnd_flag | dp_flag;

  wire trap_hit = |(new_flag & exc_en);
  wire unsup_trap = exc_valid & exc_unsup & (|(exc_flags & exc_en));

  // sticky flags: a new flag wins over the write in the same cycle
  always_comb begin
    sc_nxt = sc_r;
    if (wr_sc)
      sc_nxt = avs_writedata & `SC_WMASK;
    sc_nxt[`SC_FLAG_MSB:`SC_FLAG_LSB] =
      sc_nxt[`SC_FLAG_MSB:`SC_FLAG_LSB] | new_flag;
  end

  // ****************************************************************
  // interrupt status
  // ****************************************************************

  logic [`IRQ_W-1:0] irq_set;
  logic [`IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[`IRQ_BOUNCE_BIT] = trig_bounce;
    irq_set[`IRQ_TRAP_BIT]   = trap_hit | unsup_trap;
    irq_set[`IRQ_UNSUP_BIT]  = unsup_bounce;
    irq_clr = wr_irqst ? avs_writedata[`IRQ_W-1:0] : '0;
    irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;
  end

  assign irq = |(irq_st_r & irq_mask_r);

  // ****************************************************************
  // read mux
  // ****************************************************************

  // unmapped words read zero, writes to them are dropped
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      `OFS_STATUS_CTRL: rd_mux = sc_r;
      `OFS_EXC_CTRL:    rd_mux = {in_exc, 31'h00000000};
      `OFS_EXC_INSTR:   rd_mux = inst_r;
      `OFS_SYS_ID:      rd_mux = SYS_ID_VALUE;
      `OFS_IRQ_STATUS:  rd_mux = {29'h00000000, irq_st_r};
      `OFS_IRQ_MASK:    rd_mux = {29'h00000000, irq_mask_r};
      `OFS_LAST_RESULT: rd_mux = last_res_r;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // flip-flops
  // ****************************************************************

  // bus handshake and read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read && !ack_r)
        rdata_r <= rd_mux;
    end
  end

  // software visible state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sc_r       <= `SC_RESET;
      state_r    <= ST_NORMAL;
      inst_r     <= 32'h00000000;
      irq_st_r   <= '0;
      irq_mask_r <= '0;
    end else begin
      sc_r     <= sc_nxt;
      state_r  <= state_nxt;
      inst_r   <= inst_nxt;
      irq_st_r <= irq_st_nxt;
      if (wr_mask)
        irq_mask_r <= avs_writedata[`IRQ_W-1:0];
    end
  end

  // issue answers; a bounced instruction never reaches the datapath
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accept_r   <= 1'b0;
      bounce_r   <= 1'b0;
      dp_issue_r <= 1'b0;
      dp_instr_r <= 32'h00000000;
    end else begin
      accept_r   <= accept_now;
      bounce_r   <= bounce_now;
      dp_issue_r <= accept_now & ~iss_req.sysreg;
      if (accept_now && !iss_req.sysreg)
        dp_instr_r <= iss_req.instr;
    end
  end

  // operand flush, one cycle of latency either way
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opnd_a_r <= 32'h00000000;
      opnd_b_r <= 32'h00000000;
    end else begin
      opnd_a_r <= (ftz && is_subnormal(opnd_a_in)) ? 32'h00000000
                                                   : opnd_a_in;
      opnd_b_r <= (ftz && is_subnormal(opnd_b_in)) ? 32'h00000000
                                                   : opnd_b_in;
    end
  end

  // rounded result and trap pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rnd_done_r <= 1'b0;
      rnd_res_r  <= 32'h00000000;
      rnd_tiny_r <= 1'b0;
      rnd_inx_r  <= 1'b0;
      last_res_r <= 32'h00000000;
      trap_r     <= 1'b0;
    end else begin
      rnd_done_r <= rnd_valid;
      trap_r     <= trap_hit | unsup_trap;
      if (rnd_valid) begin
        rnd_res_r  <= final_res;
        rnd_tiny_r <= tiny;
        rnd_inx_r  <= final_inx;
        last_res_r <= final_res;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  assign avs_readdata = rdata_r;
  assign iss_accept   = accept_r;
  assign iss_bounce   = bounce_r;
  assign dp_issue     = dp_issue_r;
  assign dp_instr     = dp_instr_r;
  assign opnd_a_out   = opnd_a_r;
  assign opnd_b_out   = opnd_b_r;
  assign rnd_done     = rnd_done_r;
  assign rnd_result   = rnd_res_r;
  assign rnd_tiny     = rnd_tiny_r;
  assign rnd_inexact  = rnd_inx_r;
  assign trap         = trap_r;

endmodule
`default_nettype wire

// file: fp_round_unit.sv
// significand rounding for the four rounding modes
`include "fp_rbc_cfg.svh"
`default_nettype none
module fp_round_unit (
  input  wire logic        sign,
  input  wire logic [23:0] sig,
  input  wire logic [2:0]  grs,
  input  wire logic [1:0]  rmode,
  output logic      [24:0] sig_out,
  output logic             inexact
);
  wire lost = |grs;
  logic inc;

  // increment decision per mode
  // mode select
  always_comb begin
    case (rmode)
      `RM_NEAREST:   inc = grs[2] & (grs[1] | grs[0] | sig[0]);
      `RM_PLUS_INF:  inc = ~sign & lost;
      `RM_MINUS_INF: inc = sign & lost;
      `RM_ZERO:      inc = 1'b0;
      default:       inc = 1'b0;
    endcase
  end

  // subnormals use the same width, no early truncation
  // full precision
  assign sig_out = {1'b0, sig} + {24'h000000, inc};
  assign inexact = lost;
endmodule
`default_nettype wire

// file: host_core_model.sv
// host core model: register bus master and instruction issue
`default_nettype none
module host_core_model
  import fp_rbc_pkg::*;
(
  input  wire logic        clk,
  output logic      [2:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output logic             iss_valid,
  output iss_req_t         iss_req,
  input  wire logic        iss_accept,
  input  wire logic        iss_bounce
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    iss_valid = 1'b0;
    iss_req = '0;
  end
  // one access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // waitrequest and read data are taken at the same rising edge
    do
      @(posedge clk);
    while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
  // one offer; released fields show the inverse, not the old value
  task automatic offer(input iss_req_t r, output logic acc, output logic bnc);
    @(posedge clk);
    iss_valid <= 1'b1;
    iss_req <= r;
    @(posedge clk);
    iss_valid <= 1'b0;
    iss_req <= ~r;
    @(negedge clk);
    acc = iss_accept;
    bnc = iss_bounce;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the rounding and bounce control
`include "fp_rbc_cfg.svh"
`default_nettype none
module tb
  import fp_rbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_VAL = 32'h00001234; // arbitrary value
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic        iss_valid, iss_accept, iss_bounce, dp_issue, rnd_valid;
  logic        rnd_done, rnd_tiny, rnd_inexact, exc_valid, exc_unsup;
  logic        trap, irq, acc, bnc;
  logic [2:0]  avs_address;
  logic [4:0]  exc_flags;
  logic [23:0] sg;
  logic [31:0] avs_writedata, avs_readdata, dp_instr, rnd_result, q;
  logic [31:0] opnd_a_in, opnd_b_in, opnd_a_out, opnd_b_out;
  iss_req_t    iss_req;
  rnd_req_t    rnd_req;
  int          err_count, compares;
  fp_round_bounce_control #(.SYS_ID_VALUE(ID_VAL)) i_dut (.*);
  host_core_model i_host (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .iss_valid(iss_valid),
    .iss_req(iss_req), .iss_accept(iss_accept), .iss_bounce(iss_bounce));
  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    i_host.bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    i_host.bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic rnd(input logic s, input logic [7:0] e,
                     input logic [23:0] g, input logic [2:0] x);
    @(posedge clk);
    rnd_valid <= 1'b1;
    rnd_req <= '{s, e, g, x};
    @(posedge clk);
    rnd_valid <= 1'b0;
    rnd_req <= ~rnd_req;
    @(negedge clk);
  endtask
  task automatic exc(input logic [4:0] f, input logic u);
    @(posedge clk);
    exc_valid <= 1'b1;
    exc_flags <= f;
    exc_unsup <= u;
    @(posedge clk);
    exc_valid <= 1'b0;
    exc_flags <= ~f;
    @(negedge clk);
  endtask
  // expected rounding of a normal value with exponent 80
  function automatic logic [31:0] exp_rnd(input logic [1:0] m, input logic s,
                                          input logic [23:0] g);
    logic up;
    case (m)
      `RM_NEAREST:  up = g[0];
      `RM_ZERO:     up = 1'b0;
      `RM_PLUS_INF: up = !s;
      default:      up = s;
    endcase
    return {s, 8'h80, g[22:0] + {22'h0, up}};
  endfunction
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    rnd_valid = 1'b0;
    rnd_req = '0;
    exc_valid = 1'b0;
    exc_flags = 5'h0;
    exc_unsup = 1'b0;
    opnd_a_in = 32'h0;
    opnd_b_in = 32'h0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(a[2:0], a == 3 ? ID_VAL : 32'h0);
    wr(`OFS_STATUS_CTRL, 32'hFFFFFFFF);
    rd(`OFS_STATUS_CTRL, `SC_WMASK);
    wr(3'h7, 32'hFFFFFFFF);
    rd(3'h7, 32'h0);
    $display("registers done");
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_STATUS_CTRL, 32'(m) << `SC_RMODE_LSB);
      for (int k = 0; k < 4; k++) begin
        sg = 24'hC00000 | 24'(k[1]);
        rnd(k[0], 8'h80, sg, 3'h4);
        chk(rnd_result, exp_rnd(m[1:0], k[0], sg));
        chk(rnd_inexact, 32'h1);
      end
    end
    wr(`OFS_STATUS_CTRL, 32'h0);
    rnd(1'b0, 8'h00, 24'h000010, 3'h0);
    chk(rnd_result, 32'h00000010);
    chk(rnd_tiny, 32'h1);
    rd(`OFS_LAST_RESULT, 32'h00000010);
    wr(`OFS_STATUS_CTRL, 32'h1 << `SC_FTZ_BIT);
    opnd_a_in <= 32'h80000001;
    opnd_b_in <= 32'h3F800000;
    rnd(1'b1, 8'h00, 24'h000010, 3'h0);
    chk(rnd_result, 32'h0);
    chk(opnd_a_out, 32'h0);
    chk(opnd_b_out, 32'h3F800000);
    $display("rounding done");
    wr(`OFS_STATUS_CTRL, 32'h1 << (`SC_EN_LSB + 4));
    rnd(1'b0, 8'h80, 24'hC00000, 3'h1);
    chk(trap, 32'h1);
    exc(5'h01, 1'b0);
    chk(trap, 32'h0);
    exc(5'h10, 1'b1);
    chk(trap, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h2);
    @(negedge clk);
    chk(irq, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    @(negedge clk);
    chk(irq, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'h2);
    wr(`OFS_IRQ_STATUS, 32'h7);
    rd(`OFS_IRQ_STATUS, 32'h0);
    $display("traps done");
    wr(`OFS_STATUS_CTRL, 32'h3 << `SC_STRIDE_LSB);
    i_host.offer('{32'h00004000, 1'b1, 1'b0, 1'b0, 2'h0, 3'h2}, acc, bnc);
    chk(acc, 32'h1);
    chk(dp_issue, 32'h1);
    chk(dp_instr, 32'h00004000);
    rd(`OFS_EXC_INSTR, 32'h00008000);
    rd(`OFS_EXC_CTRL, 32'h80000000);
    i_host.offer('{32'h0, 1'b0, 1'b0, 1'b1, `SYSSEL_EXC, 3'h0}, acc, bnc);
    chk(acc, 32'h1);
    i_host.offer('{32'h00001000, 1'b0, 1'b0, 1'b0, 2'h0, 3'h0}, acc, bnc);
    chk(bnc, 32'h1);
    chk(dp_issue, 32'h0);
    chk(dp_instr, 32'h00004000);
    i_host.offer('{32'h0, 1'b0, 1'b0, 1'b1, `SYSSEL_INSTR, 3'h0}, acc, bnc);
    chk(acc, 32'h1);
    i_host.offer('{32'h0, 1'b0, 1'b0, 1'b1, `SYSSEL_ID, 3'h0}, acc, bnc);
    chk(acc, 32'h1);
    i_host.offer('{32'h0, 1'b0, 1'b0, 1'b1, 2'h0, 3'h0}, acc, bnc);
    chk(bnc, 32'h1);
    rd(`OFS_EXC_INSTR, 32'h00008000);
    rd(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_EXC_CTRL, 32'h0);
    wr(`OFS_IRQ_STATUS, 32'h7);
    wr(`OFS_STATUS_CTRL, 32'h0);
    i_host.offer('{32'h00004000, 1'b1, 1'b0, 1'b0, 2'h0, 3'h3}, acc, bnc);
    rd(`OFS_EXC_INSTR, 32'h00007000);
    wr(`OFS_EXC_CTRL, 32'h0);
    i_host.offer('{32'h00001000, 1'b0, 1'b1, 1'b0, 2'h0, 3'h0}, acc, bnc);
    chk(bnc, 32'h1);
    rd(`OFS_EXC_CTRL, 32'h0);
    rd(`OFS_IRQ_STATUS, 32'h4);
    $display("bounce done");
    close_out();
  end
endmodule
`default_nettype wire

// file: vec_reg_stepper.sv
// register number of one short vector iteration
`include "fp_rbc_cfg.svh"
`default_nettype none
module vec_reg_stepper (
  input  wire logic [3:0] base_reg,
  input  wire logic [1:0] stride,
  input  wire logic [2:0] iter,
  output logic      [3:0] iter_reg
);
  // other stride codes step by one so nothing ever stalls
  // stride step
  wire [3:0] step = (stride == `STRIDE_TWO) ? 4'h2 : 4'h1;

  // wraps inside the register bank
  assign iter_reg = base_reg + 4'(iter) * step;
endmodule
`default_nettype wire
